// [rtl/spmsb_pkg.sv]
// spmsb_pkg: constants and types shared by the serial byte port files
// assumes a single 25 MHz core clock; pins are already synchronous to it
package spmsb_pkg;

  localparam int unsigned DATA_W     = 8;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned BITS_PER_BYTE = 8;

  // core clock rate and the least sck phase an outside master must keep
  localparam int unsigned CLK_HZ            = 25_000_000;
  localparam int unsigned SLAVE_MIN_PHASE_CYC = 2;

  // sck divisors of the core clock, selected by the rate port
  localparam int unsigned DIV_RATE0 = 4;
  localparam int unsigned DIV_RATE1 = 16;
  localparam int unsigned DIV_RATE2 = 64;
  localparam int unsigned DIV_RATE3 = 128;
  localparam int unsigned DOUBLE_SPEED_SHIFT = 1;

  localparam int unsigned HALF_W = 7;
  localparam logic [HALF_W-1:0] HALF_RATE0 = HALF_W'(DIV_RATE0 / 2);
  localparam logic [HALF_W-1:0] HALF_RATE1 = HALF_W'(DIV_RATE1 / 2);
  localparam logic [HALF_W-1:0] HALF_RATE2 = HALF_W'(DIV_RATE2 / 2);
  localparam logic [HALF_W-1:0] HALF_RATE3 = HALF_W'(DIV_RATE3 / 2);
  localparam logic [HALF_W-1:0] HALF_ONE   = 7'h01;

  localparam logic [1:0] RATE_SEL0 = 2'h0;
  localparam logic [1:0] RATE_SEL1 = 2'h1;
  localparam logic [1:0] RATE_SEL2 = 2'h2;

  localparam logic [3:0] BIT_LAST  = 4'h7;
  localparam logic [3:0] BIT_ZERO  = 4'h0;
  localparam logic [3:0] BIT_ONE   = 4'h1;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;

  typedef enum logic [1:0] {
    SPMSB_IDLE,
    SPMSB_WAIT,
    SPMSB_LOW,
    SPMSB_HIGH
  } spmsb_state_t;

endpackage : spmsb_pkg

// [rtl/spmsb_fifo_if.sv]
// spmsb_fifo_if: valid/ready byte stream between the port and its fifo
// assumes both ends run on the same clock
`timescale 1ns/1ns
interface spmsb_fifo_if #(
  parameter int unsigned W = 8
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface : spmsb_fifo_if

// [rtl/spmsb_fifo.sv]
// spmsb_fifo: synchronous fifo, head word held in a register
// assumes one clock; push ignored when full, pop ignored when empty
`timescale 1ns/1ns
module spmsb_fifo #(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic   clk_i,   // core clock
  input  wire logic   rst_i,   // async reset, high
  spmsb_fifo_if.sink   in_if,  // filling side
  spmsb_fifo_if.source out_if  // draining side
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0]   count;
  logic [W-1:0]  dout;
  logic [AW-1:0] next_wptr;
  logic [AW-1:0] next_rptr;
  logic [AW:0]   next_count;
  logic [W-1:0]  next_dout;
  logic          in_fire;
  logic          out_fire;

  assign in_if.ready  = (count != (AW+1)'(DEPTH));
  assign out_if.valid = (count != '0);
  assign out_if.data  = dout;
  assign in_fire      = in_if.valid && in_if.ready;
  assign out_fire     = out_if.valid && out_if.ready;

  always_comb
  begin
    next_wptr  = in_fire ? wptr + AW'(1) : wptr;
    next_rptr  = out_fire ? rptr + AW'(1) : rptr;
    next_count = count + (AW+1)'(in_fire) - (AW+1)'(out_fire);
    // bypass so a write into an empty head is seen next cycle
    if (in_fire && (wptr == next_rptr))
      next_dout = in_if.data;
    else
      next_dout = mem[next_rptr];
  end

  always_ff @(posedge clk_i)
  begin
    if (in_fire)
      mem[wptr] <= in_if.data;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
      dout  <= '0;
    end
    else
    begin
      wptr  <= next_wptr;
      rptr  <= next_rptr;
      count <= next_count;
      dout  <= next_dout;
    end
  end
endmodule : spmsb_fifo

// [rtl/spmsb_port.sv]
// spmsb_port: byte-wide full-duplex serial port, master or slave, mode 0
// assumes pins are synchronous to clk_i; received bytes queue in a fifo
`timescale 1ns/1ns
module spmsb_port #(
  parameter int unsigned W     = spmsb_pkg::DATA_W,
  parameter int unsigned DEPTH = spmsb_pkg::FIFO_DEPTH
) (
  input  wire logic         clk_i,            // core clock
  input  wire logic         rst_i,            // async reset, high
  input  wire logic         enable_i,         // port enable
  input  wire logic         ctrl_wr_i,        // load master_select_i
  input  wire logic         master_select_i,  // requested master mode
  output logic              master_select_o,  // current master mode
  input  wire logic         lsb_first_i,      // shift order
  input  wire logic [1:0]   rate_i,           // sck divisor select
  input  wire logic         double_speed_i,   // halve the divisor
  input  wire logic         transfer_irq_enable_i, // irq enable
  input  wire logic         wr_i,             // data register write
  input  wire logic [W-1:0] wr_data_i,        // byte to send
  input  wire logic         rd_i,             // data register read
  output logic [W-1:0]      rd_data_o,        // received byte
  output logic              rx_avail_o,       // fifo holds a byte
  input  wire logic         status_rd_i,      // status register read
  input  wire logic         irq_ack_i,        // interrupt entry
  output logic              transfer_done_flag_o, // byte finished
  output logic              write_collision_o,    // write while busy
  output logic              busy_o,           // transfer in progress
  output logic              irq_o,            // interrupt request
  input  wire logic         mosi_dir_i,       // user mosi direction
  input  wire logic         miso_dir_i,       // user miso direction
  input  wire logic         sck_dir_i,        // user sck direction
  input  wire logic         ss_dir_i,         // user ss direction
  input  wire logic         ss_level_i,       // user ss output level
  input  wire logic         sck_i,            // sck pin in
  output logic              sck_o,            // sck pin out
  output logic              sck_oe_o,         // sck drive enable
  input  wire logic         mosi_i,           // mosi pin in
  output logic              mosi_o,           // mosi pin out
  output logic              mosi_oe_o,        // mosi drive enable
  input  wire logic         miso_i,           // miso pin in
  output logic              miso_o,           // miso pin out
  output logic              miso_oe_o,        // miso drive enable
  input  wire logic         ss_i,             // ss pin in, low selects
  output logic              ss_o,             // ss pin out
  output logic              ss_oe_o           // ss drive enable
);
  spmsb_fifo_if #(.W(W)) rx_in ();
  spmsb_fifo_if #(.W(W)) rx_out ();

  spmsb_pkg::spmsb_state_t state;
  spmsb_pkg::spmsb_state_t next_state;
  logic [W-1:0]  shreg;
  logic [W-1:0]  next_shreg;
  logic [3:0]    bits;
  logic [3:0]    next_bits;
  logic [spmsb_pkg::HALF_W-1:0] cnt;
  logic [spmsb_pkg::HALF_W-1:0] next_cnt;
  logic [spmsb_pkg::HALF_W-1:0] half;
  logic          sck;
  logic          next_sck;
  logic          samp;
  logic          next_samp;
  logic          sck_prev;
  logic          master_select;
  logic          next_master_select;
  logic          done_flag;
  logic          next_done_flag;
  logic          wcol;
  logic          next_wcol;
  logic          armed;
  logic          next_armed;
  logic          push;
  logic          next_push;
  logic [W-1:0]  rx_byte;
  logic [W-1:0]  next_rx_byte;
  logic [W-1:0]  rdata;
  logic [W-1:0]  next_rdata;
  logic          done;
  logic          busy;
  logic          is_master;
  logic          is_slave;
  logic          sel;
  logic          mode_fault;
  logic          clear_flags;
  logic [W-1:0]  shifted;

  spmsb_fifo #(.W(W), .DEPTH(DEPTH)) u_rx_fifo (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .in_if  (rx_in.sink),
    .out_if (rx_out.source)
  );

  assign is_master  = enable_i && master_select;
  assign is_slave   = enable_i && !master_select;
  assign sel        = !ss_i;
  assign mode_fault = is_master && !ss_dir_i && !ss_i;
  assign busy       = is_master ? (state != spmsb_pkg::SPMSB_IDLE)
                                : (sel && (bits != spmsb_pkg::BIT_ZERO));
  assign shifted    = lsb_first_i ? {samp, shreg[W-1:1]}
                                  : {shreg[W-2:0], samp};

  always_comb
  begin
    case (rate_i)
      spmsb_pkg::RATE_SEL0: half = spmsb_pkg::HALF_RATE0;
      spmsb_pkg::RATE_SEL1: half = spmsb_pkg::HALF_RATE1;
      spmsb_pkg::RATE_SEL2: half = spmsb_pkg::HALF_RATE2;
      default:              half = spmsb_pkg::HALF_RATE3;
    endcase
    if (double_speed_i)
      half = half >> spmsb_pkg::DOUBLE_SPEED_SHIFT;
  end

  always_comb
  begin
    next_state = state;
    next_shreg = shreg;
    next_bits  = bits;
    next_cnt   = cnt;
    next_sck   = sck;
    next_samp  = samp;
    next_master_select  = master_select;
    done       = 1'b0;
    if (ctrl_wr_i)
      next_master_select = master_select_i;
    if (!enable_i)
    begin
      next_state = spmsb_pkg::SPMSB_IDLE;
      next_sck   = 1'b0;
      next_bits  = spmsb_pkg::BIT_ZERO;
    end
    else if (master_select)
    begin
      case (state)
        spmsb_pkg::SPMSB_IDLE:
        begin
          if (wr_i)
          begin
            next_shreg = wr_data_i;
            next_bits  = spmsb_pkg::BIT_ZERO;
            next_state = spmsb_pkg::SPMSB_WAIT;
          end
        end
        spmsb_pkg::SPMSB_WAIT:
        begin
          // a full receive fifo holds the start back
          if (rx_in.ready)
          begin
            next_cnt   = half - spmsb_pkg::HALF_ONE;
            next_state = spmsb_pkg::SPMSB_LOW;
          end
        end
        spmsb_pkg::SPMSB_LOW:
        begin
          if (cnt == '0)
          begin
            next_sck   = 1'b1;
            next_samp  = miso_i;
            next_cnt   = half - spmsb_pkg::HALF_ONE;
            next_state = spmsb_pkg::SPMSB_HIGH;
          end
          else
            next_cnt = cnt - spmsb_pkg::HALF_ONE;
        end
        spmsb_pkg::SPMSB_HIGH:
        begin
          if (cnt == '0)
          begin
            next_sck   = 1'b0;
            next_shreg = shifted;
            next_cnt   = half - spmsb_pkg::HALF_ONE;
            if (bits == spmsb_pkg::BIT_LAST)
            begin
              done       = 1'b1;
              next_bits  = spmsb_pkg::BIT_ZERO;
              next_state = spmsb_pkg::SPMSB_IDLE;
            end
            else
            begin
              next_bits  = bits + spmsb_pkg::BIT_ONE;
              next_state = spmsb_pkg::SPMSB_LOW;
            end
          end
          else
            next_cnt = cnt - spmsb_pkg::HALF_ONE;
        end
        default: next_state = spmsb_pkg::SPMSB_IDLE;
      endcase
      if (mode_fault)
      begin
        next_master_select  = 1'b0;
        next_state = spmsb_pkg::SPMSB_IDLE;
        next_sck   = 1'b0;
        next_bits  = spmsb_pkg::BIT_ZERO;
      end
    end
    else
    begin
      next_state = spmsb_pkg::SPMSB_IDLE;
      next_sck   = 1'b0;
      if (wr_i && !busy)
        next_shreg = wr_data_i;
      if (!sel)
        next_bits = spmsb_pkg::BIT_ZERO;
      else if (sck_i && !sck_prev)
        next_samp = mosi_i;
      else if (!sck_i && sck_prev)
      begin
        next_shreg = shifted;
        if (bits == spmsb_pkg::BIT_LAST)
        begin
          done      = 1'b1;
          next_bits = spmsb_pkg::BIT_ZERO;
        end
        else
          next_bits = bits + spmsb_pkg::BIT_ONE;
      end
    end
  end

  // status read then data access, or interrupt entry
  assign clear_flags = irq_ack_i || (armed && (rd_i || wr_i));

  always_comb
  begin
    next_armed = armed;
    if (status_rd_i)
      next_armed = done_flag || wcol;
    else if (rd_i || wr_i || irq_ack_i)
      next_armed = 1'b0;
    // set wins over clear
    next_done_flag = done || (done_flag && !clear_flags);
    next_wcol = (wr_i && busy) || (wcol && !clear_flags);
    next_push    = done;
    next_rx_byte = done ? shifted : rx_byte;
    next_rdata   = rdata;
    if (rd_i)
      next_rdata = rx_out.valid ? rx_out.data : spmsb_pkg::BYTE_ZERO;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state     <= spmsb_pkg::SPMSB_IDLE;
      shreg     <= spmsb_pkg::BYTE_ZERO;
      bits      <= spmsb_pkg::BIT_ZERO;
      cnt       <= '0;
      sck       <= 1'b0;
      samp      <= 1'b0;
      sck_prev  <= 1'b0;
      master_select      <= 1'b0;
      done_flag <= 1'b0;
      wcol      <= 1'b0;
      armed     <= 1'b0;
      push      <= 1'b0;
      rx_byte   <= spmsb_pkg::BYTE_ZERO;
      rdata     <= spmsb_pkg::BYTE_ZERO;
    end
    else
    begin
      state     <= next_state;
      shreg     <= next_shreg;
      bits      <= next_bits;
      cnt       <= next_cnt;
      sck       <= next_sck;
      samp      <= next_samp;
      sck_prev  <= sck_i;
      master_select      <= next_master_select;
      done_flag <= next_done_flag;
      wcol      <= next_wcol;
      armed     <= next_armed;
      push      <= next_push;
      rx_byte   <= next_rx_byte;
      rdata     <= next_rdata;
    end
  end

  // slave bytes arriving into a full fifo are lost
  assign rx_in.valid  = push;
  assign rx_in.data   = rx_byte;
  assign rx_out.ready = rd_i;

  assign master_select_o      = master_select;
  assign rd_data_o            = rdata;
  assign rx_avail_o           = rx_out.valid;
  assign transfer_done_flag_o = done_flag;
  assign write_collision_o    = wcol;
  assign busy_o               = busy;
  assign irq_o = done_flag && transfer_irq_enable_i;

  assign sck_o     = sck;
  assign mosi_o    = lsb_first_i ? shreg[0] : shreg[W-1];
  assign miso_o    = lsb_first_i ? shreg[0] : shreg[W-1];
  assign ss_o      = ss_level_i;
  assign sck_oe_o  = is_master && sck_dir_i;
  assign mosi_oe_o = is_master && mosi_dir_i;
  assign ss_oe_o   = is_master && ss_dir_i;
  assign miso_oe_o = is_slave && miso_dir_i && sel;

  property p_start;
    @(posedge clk_i) disable iff (rst_i)
    (is_master && !mode_fault && !ctrl_wr_i && wr_i
      && state == spmsb_pkg::SPMSB_IDLE) |=> busy;
  endproperty
  a_start: assert property (p_start)
    else $error("master write did not start a transfer");

  property p_done;
    @(posedge clk_i) disable iff (rst_i)
    (is_master && done) |=> (done_flag && !sck_o && !busy_o) ##1 push == 1'b0;
  endproperty
  a_done: assert property (p_done)
    else $error("master completion did not stop and flag");

  property p_irq;
    @(posedge clk_i) disable iff (rst_i)
    (done && transfer_irq_enable_i) |=> irq_o;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt missing with flag and enable");

  property p_ss_user;
    @(posedge clk_i) disable iff (rst_i)
    is_master |-> (ss_o == ss_level_i && ss_oe_o == ss_dir_i);
  endproperty
  a_ss_user: assert property (p_ss_user)
    else $error("select pin not under user control");

  property p_miso_idle;
    @(posedge clk_i) disable iff (rst_i)
    (is_slave && ss_i) |-> !miso_oe_o ##1 (!enable_i || master_select || bits == '0);
  endproperty
  a_miso_idle: assert property (p_miso_idle)
    else $error("deselected slave drove miso or counted bits");

  property p_ss_reset;
    @(posedge clk_i) disable iff (rst_i)
    (is_slave && $rose(ss_i)) |=> (bits == spmsb_pkg::BIT_ZERO);
  endproperty
  a_ss_reset: assert property (p_ss_reset)
    else $error("rising select did not reset slave shifter");

  property p_wcol;
    @(posedge clk_i) disable iff (rst_i)
    (wr_i && busy) |=> write_collision_o;
  endproperty
  a_wcol: assert property (p_wcol)
    else $error("write during transfer not flagged");

  property p_fault;
    @(posedge clk_i) disable iff (rst_i)
    mode_fault |=> (!master_select_o && !sck_oe_o && !busy_o);
  endproperty
  a_fault: assert property (p_fault)
    else $error("low select did not drop master mode");

  property p_push;
    @(posedge clk_i) disable iff (rst_i)
    done |=> (rx_in.valid && rx_in.data == $past(shifted));
  endproperty
  a_push: assert property (p_push)
    else $error("completed byte not sent to receive buffer");

  property p_dirs;
    @(posedge clk_i) disable iff (rst_i)
    is_master |-> (!miso_oe_o && sck_oe_o == sck_dir_i);
  endproperty
  a_dirs: assert property (p_dirs)
    else $error("master pin directions wrong");

endmodule : spmsb_port

// [verif/spmsb_far_slave.sv]
// spmsb_far_slave: behavioural serial slave facing the port as master
// assumes mode 0: sample on sck rise, change on sck fall
`timescale 1ns/1ns
module spmsb_far_slave (
  input  wire logic       sck_i,       // serial clock
  input  wire logic       mosi_i,      // data from master
  input  wire logic       ss_n_i,      // select, low active
  input  wire logic       lsb_first_i, // shift order
  input  wire logic       slow_i,      // late miso changes
  input  wire logic [7:0] tx_i,        // byte to return
  output logic            miso_o,      // data to master
  output logic [7:0]      rx_o         // last byte taken in
);
  logic [7:0] sh;
  initial
  begin
    miso_o = 1'b0;
    rx_o   = 8'h00;
    sh     = 8'h00;
  end
  always @(negedge ss_n_i)
  begin
    sh     = tx_i;
    miso_o = lsb_first_i ? tx_i[0] : tx_i[7];
  end
  // released line has no pull: never let it keep the last bit
  always @(posedge ss_n_i)
    miso_o = ~miso_o;
  always @(posedge sck_i)
    if (!ss_n_i)
      rx_o = lsb_first_i ? {mosi_i, rx_o[7:1]} : {rx_o[6:0], mosi_i};
  always @(negedge sck_i)
    if (!ss_n_i)
    begin
      sh = lsb_first_i ? (sh >> 1) : (sh << 1);
      #(slow_i ? 15 : 1);
      // a release during the delay keeps the inverted level
      if (!ss_n_i)
        miso_o = lsb_first_i ? sh[0] : sh[7];
    end
endmodule : spmsb_far_slave

// [verif/tb.sv]
// tb: self-checking bench for spmsb_port, master and slave modes
// assumes the far slave model in spmsb_far_slave.sv
`timescale 1ns/1ns
`define CHK(nm, exp, got) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("ERROR %s exp %0h got %0h", nm, exp, got); \
    end \
  end
module tb;
  logic clk_i, rst_i, enable_i, ctrl_wr_i, master_select_i, lsb_first_i;
  logic double_speed_i, transfer_irq_enable_i, wr_i, rd_i, status_rd_i;
  logic irq_ack_i, mosi_dir_i, miso_dir_i, sck_dir_i, ss_dir_i, ss_level_i;
  logic [1:0] rate_i;
  logic [7:0] wr_data_i, rd_data_o, far_tx, far_rx, cap;
  logic master_select_o, rx_avail_o, transfer_done_flag_o;
  logic write_collision_o, busy_o, irq_o, sck_o, sck_oe_o, mosi_o;
  logic mosi_oe_o, miso_o, miso_oe_o, ss_o, ss_oe_o;
  logic sck_i, mosi_i, miso_i, ss_i, far_miso;
  logic tb_sck, tb_mosi, tb_ss_n, far_slow;
  int   mismatches, total_checks, hi_cnt;

  spmsb_port spmsb_port_inst (
    .clk_i, .rst_i, .enable_i, .ctrl_wr_i, .master_select_i,
    .master_select_o, .lsb_first_i, .rate_i, .double_speed_i,
    .transfer_irq_enable_i, .wr_i, .wr_data_i, .rd_i, .rd_data_o,
    .rx_avail_o, .status_rd_i, .irq_ack_i, .transfer_done_flag_o,
    .write_collision_o, .busy_o, .irq_o, .mosi_dir_i, .miso_dir_i,
    .sck_dir_i, .ss_dir_i, .ss_level_i, .sck_i, .sck_o, .sck_oe_o,
    .mosi_i, .mosi_o, .mosi_oe_o, .miso_i, .miso_o, .miso_oe_o,
    .ss_i, .ss_o, .ss_oe_o
  );
  spmsb_far_slave spmsb_far_slave_inst (
    .sck_i(sck_i), .mosi_i(mosi_i), .ss_n_i(ss_i),
    .lsb_first_i(lsb_first_i), .slow_i(far_slow), .tx_i(far_tx),
    .miso_o(far_miso), .rx_o(far_rx)
  );
  assign sck_i  = sck_oe_o  ? sck_o  : tb_sck;
  assign mosi_i = mosi_oe_o ? mosi_o : tb_mosi;
  assign miso_i = miso_oe_o ? miso_o : far_miso;
  assign ss_i   = ss_oe_o   ? ss_o   : tb_ss_n;

  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
    if (sck_o === 1'b1)
      hi_cnt++;

  task automatic step;
    @(posedge clk_i);
    #2;
  endtask : step
  task automatic pulse(ref logic s);
    s = 1'b1;
    step;
    s = 1'b0;
  endtask : pulse
  task automatic wait_idle;
    int k;
    k = 0;
    while (busy_o !== 1'b0 && k < 5000)
    begin
      step;
      k++;
    end
    // a hung transfer counts as a mismatch
    if (k >= 5000)
      mismatches++;
  endtask : wait_idle
  function automatic int half();
    int d;
    case (rate_i)
      2'h0: d = spmsb_pkg::DIV_RATE0;
      2'h1: d = spmsb_pkg::DIV_RATE1;
      2'h2: d = spmsb_pkg::DIV_RATE2;
      default: d = spmsb_pkg::DIV_RATE3;
    endcase
    return (d >> (double_speed_i ? spmsb_pkg::DOUBLE_SPEED_SHIFT : 0)) / 2;
  endfunction : half
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  // one master byte; coll adds a write while busy
  task automatic xfer(input logic [7:0] tx, input logic [7:0] fx,
                      input bit coll);
    far_tx     = fx;
    ss_level_i = 1'b0;
    step;
    hi_cnt    = 0;
    wr_data_i = tx;
    wr_i      = 1'b1;
    step;
    // strobe held high so the second write lands on the next edge
    if (coll)
    begin
      wr_data_i = ~tx;
      step;
      `CHK("collision", 1'b1, write_collision_o)
    end
    wr_i = 1'b0;
    wait_idle;
    `CHK("done flag", 1'b1, transfer_done_flag_o)
    `CHK("sck high cycles", 8 * half(), hi_cnt)
    `CHK("far byte", tx, far_rx)
    `CHK("irq", transfer_irq_enable_i, irq_o)
    `CHK("select held", 1'b0, ss_o)
    ss_level_i = 1'b1;
    // let the far side see the release before the next select
    step;
  endtask : xfer
  task automatic rd_chk(input logic [7:0] exp);
    pulse(status_rd_i);
    pulse(rd_i);
    `CHK("read byte", exp, rd_data_o)
    `CHK("flag cleared", 1'b0, transfer_done_flag_o)
    `CHK("collision cleared", 1'b0, write_collision_o)
  endtask : rd_chk
  // outside master: each sck phase three core cycles
  task automatic s_bits(input logic [7:0] mo, input int n);
    cap = 8'h00;
    for (int i = 0; i < n; i++)
    begin
      tb_mosi = mo[lsb_first_i ? i : 7 - i];
      repeat (3) step;
      tb_sck = 1'b1;
      cap[lsb_first_i ? i : 7 - i] = miso_i;
      repeat (3) step;
      tb_sck = 1'b0;
    end
    repeat (3) step;
  endtask : s_bits

  initial
  begin
    #(40 * 60000);
    mismatches++;
    end_sim;
  end

  initial
  begin
    logic [7:0] a;
    {enable_i, ctrl_wr_i, master_select_i, lsb_first_i} = 4'h8;
    {double_speed_i, transfer_irq_enable_i, wr_i, rd_i} = 4'h0;
    {status_rd_i, irq_ack_i, mosi_dir_i, miso_dir_i} = 4'h0;
    {sck_dir_i, ss_dir_i, ss_level_i, far_slow} = 4'h2;
    {tb_sck, tb_mosi, tb_ss_n} = 3'h1;
    rate_i = 2'h0;
    wr_data_i = 8'h00;
    far_tx = 8'h00;
    mismatches = 0;
    total_checks = 0;
    rst_i = 1'b1;
    repeat (3) step;
    rst_i = 1'b0;
    `CHK("reset miso oe", 1'b0, miso_oe_o)
    master_select_i = 1'b1;
    pulse(ctrl_wr_i);
    {sck_dir_i, mosi_dir_i, ss_dir_i} = 3'h7;
    #1;
    `CHK("master oe", 4'hE, {sck_oe_o, mosi_oe_o, ss_oe_o, miso_oe_o})
    // every order, rate and speed; back to back writes
    for (int l = 0; l < 2; l++)
      for (int r = 0; r < 8; r++)
      begin
        lsb_first_i = l[0];
        rate_i = r[1:0];
        double_speed_i = r[2];
        transfer_irq_enable_i = r[0];
        far_slow = r[1];
        a = 8'h5A ^ 8'(r * 17 + l);
        xfer(a, ~{a[3:0], a[7:4]}, r == 5);
        if (r == 7)
        begin
          pulse(irq_ack_i);
          `CHK("ack clears", 2'h0, {transfer_done_flag_o, irq_o})
        end
        rd_chk(~{a[3:0], a[7:4]});
      end
    // fill the receive queue, then one more write must wait
    {lsb_first_i, rate_i, double_speed_i, transfer_irq_enable_i} = 5'h02;
    for (int i = 0; i < 16; i++)
      xfer(8'(i), 8'hC0 + 8'(i), 1'b0);
    far_tx = 8'hEE;
    ss_level_i = 1'b0;
    step;
    hi_cnt = 0;
    wr_data_i = 8'h77;
    pulse(wr_i);
    repeat (40) step;
    `CHK("held while full", 2'h2, {busy_o, hi_cnt != 0})
    rd_chk(8'hC0);
    wait_idle;
    `CHK("late byte", 8'h77, far_rx)
    ss_level_i = 1'b1;
    for (int i = 1; i < 16; i++)
      rd_chk(8'hC0 + 8'(i));
    rd_chk(8'hEE);
    `CHK("queue empty", 1'b0, rx_avail_o)
    // select pin as input pulled low by another master
    ss_dir_i = 1'b0;
    step;
    tb_ss_n = 1'b0;
    repeat (2) step;
    `CHK("mode fault", 1'b0, master_select_o)
    tb_ss_n = 1'b1;
    miso_dir_i = 1'b1;
    transfer_irq_enable_i = 1'b1;
    step;
    `CHK("slave oe", 4'h0, {sck_oe_o, mosi_oe_o, ss_oe_o, miso_oe_o})
    wr_data_i = 8'hC3;
    pulse(wr_i);
    s_bits(8'hFF, 8);
    `CHK("deselected idle", 3'h0, {transfer_done_flag_o, rx_avail_o, write_collision_o})
    tb_ss_n = 1'b0;
    s_bits(8'h5A, 8);
    `CHK("slave reply", 8'hC3, cap)
    `CHK("slave done irq", 2'h3, {transfer_done_flag_o, irq_o})
    wr_data_i = 8'h96;
    pulse(wr_i);
    `CHK("early load", 1'b0, write_collision_o)
    tb_ss_n = 1'b1;
    lsb_first_i = 1'b1;
    step;
    tb_ss_n = 1'b0;
    s_bits(8'h81, 8);
    `CHK("slave lsb reply", 8'h96, cap)
    s_bits(8'h0F, 3);
    tb_ss_n = 1'b1;
    step;
    tb_ss_n = 1'b0;
    s_bits(8'h3C, 8);
    tb_ss_n = 1'b1;
    rd_chk(8'h5A);
    rd_chk(8'h81);
    rd_chk(8'h3C);
    // a disabled port drives no pin even when selected
    tb_ss_n = 1'b0;
    step;
    `CHK("selected miso oe", 1'b1, miso_oe_o)
    enable_i = 1'b0;
    #1;
    `CHK("disabled miso oe", 1'b0, miso_oe_o)
    end_sim;
  end
endmodule : tb
